// file: glc_top.v
// Functional notes
// - Bank A low mode 00 leaves lines 3:0 GPIO.
// - Mode 01 drives line 2 from lines 1:0.
// - Mode 10 drives line 3 from lines 2:0.
// - Mode 11 drives lines 4:3 from two tables.
// - Table B upper nibble sets line 14 output.
// - Upper nibble used only in high 2-to-1.
// - Table B lower nibble sets line 10 output.
// - Lower nibble used only in low 2-to-1.
// - Bank A bits 5:4 govern lines 7:6.
// - Table A lower nibble sets line 2 output.
`timescale 1ns/1ps
`include "glc_map.vh"

module glc_top #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst,
  // Register port from the serial slave
  input  wire             reg_wr,
  input  wire             reg_rd,
  input  wire [7:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  output reg  [7:0]       reg_rdata_q,
  // I/O lines
  input  wire [WIDTH-1:0] io_pin,
  input  wire [WIDTH-1:0] gpio_data,
  output reg  [WIDTH-1:0] io_out,
  output reg  [WIDTH-1:0] lut_drive
);

  reg  [WIDTH-1:0] io_meta_q;
  reg  [WIDTH-1:0] io_sync_q;
  reg  [1:0]       a_low_q;
  reg  [1:0]       a_high_q;
  reg  [1:0]       b_low_q;
  reg  [1:0]       b_high_q;
  reg  [7:0]       tbl_b2_q;
  reg  [7:0]       tbl_a2_q;
  reg  [7:0]       tbl_a3_q;
  reg  [7:0]       tbl_a3_fst_q;
  reg  [7:0]       tbl_a3_snd_q;
  reg  [7:0]       tbl_a3_high_q;
  reg  [7:0]       rdata_d;

  // Table bit n is the output for select value n.
  function lut2;
    input [3:0] tbl;
    input [1:0] sel;
    begin
      lut2 = tbl[sel];
    end
  endfunction

  function lut3;
    input [7:0] tbl;
    input [2:0] sel;
    begin
      lut3 = tbl[sel];
    end
  endfunction

  // Picks one two-bit mode field out of a register byte.
  function [1:0] mode_field;
    input [7:0] val;
    input [2:0] lsb;
    begin
      mode_field = val[lsb +: 2];
    end
  endfunction

  // Reserved mode bits read back as zero.
  function [7:0] pack_mode;
    input [1:0] high;
    input [1:0] low;
    begin
      pack_mode = {2'h0, high, 2'h0, low};
    end
  endfunction

  // Pin levels pass two flip-flops before the lookup reads them.
  // A pin change therefore reaches io_out two edges later.
  always @(posedge mclk) begin
    if (rst) begin
      io_meta_q <= {WIDTH{1'b0}};
      io_sync_q <= {WIDTH{1'b0}};
    end else begin
      io_meta_q <= io_pin;
      io_sync_q <= io_meta_q;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      a_low_q       <= `GLC_RST_MODE;
      a_high_q      <= `GLC_RST_MODE;
      b_low_q       <= `GLC_RST_MODE;
      b_high_q      <= `GLC_RST_MODE;
      tbl_b2_q      <= `GLC_RST_TABLE;
      tbl_a2_q      <= `GLC_RST_TABLE;
      tbl_a3_q      <= `GLC_RST_TABLE;
      tbl_a3_fst_q  <= `GLC_RST_TABLE;
      tbl_a3_snd_q  <= `GLC_RST_TABLE;
      tbl_a3_high_q <= `GLC_RST_TABLE;
    end else if (reg_wr) begin
      // Writes to unmapped addresses are dropped silently.
      case (reg_addr)
        `GLC_ADDR_MODE_A: begin
          a_low_q  <= mode_field(reg_wdata, `GLC_MODE_LOW_LSB);
          a_high_q <= mode_field(reg_wdata, `GLC_MODE_HIGH_LSB);
        end
        `GLC_ADDR_MODE_B: begin
          b_low_q  <= mode_field(reg_wdata, `GLC_MODE_LOW_LSB);
          b_high_q <= mode_field(reg_wdata, `GLC_MODE_HIGH_LSB);
        end
        `GLC_ADDR_TABLE_B2:      tbl_b2_q      <= reg_wdata;
        `GLC_ADDR_TABLE_A2:      tbl_a2_q      <= reg_wdata;
        `GLC_ADDR_TABLE_A3:      tbl_a3_q      <= reg_wdata;
        `GLC_ADDR_TABLE_A3_FST:  tbl_a3_fst_q  <= reg_wdata;
        `GLC_ADDR_TABLE_A3_SND:  tbl_a3_snd_q  <= reg_wdata;
        `GLC_ADDR_TABLE_A3_HIGH: tbl_a3_high_q <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Reserved mode bits read as zero; unmapped addresses read zero.
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `GLC_ADDR_MODE_A:        rdata_d = pack_mode(a_high_q, a_low_q);
      `GLC_ADDR_MODE_B:        rdata_d = pack_mode(b_high_q, b_low_q);
      `GLC_ADDR_TABLE_B2:      rdata_d = tbl_b2_q;
      `GLC_ADDR_TABLE_A2:      rdata_d = tbl_a2_q;
      `GLC_ADDR_TABLE_A3:      rdata_d = tbl_a3_q;
      `GLC_ADDR_TABLE_A3_FST:  rdata_d = tbl_a3_fst_q;
      `GLC_ADDR_TABLE_A3_SND:  rdata_d = tbl_a3_snd_q;
      `GLC_ADDR_TABLE_A3_HIGH: rdata_d = tbl_a3_high_q;
      default:                 rdata_d = 8'h00;
    endcase
  end

  // A read in the same cycle as a write returns the old contents.
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  always @* begin
    // Lines not claimed by a lookup keep their data register value.
    io_out    = gpio_data;
    lut_drive = {WIDTH{1'b0}};
    case (a_low_q)
      `GLC_MODE_GPIO: begin
      end
      `GLC_MODE_TWO_TO_ONE: begin
        io_out[2]    = lut2(tbl_a2_q[3:0], io_sync_q[1:0]);
        lut_drive[2] = 1'b1;
      end
      `GLC_MODE_THREE_TO_ONE: begin
        io_out[3]    = lut3(tbl_a3_q, io_sync_q[2:0]);
        lut_drive[3] = 1'b1;
      end
      `GLC_MODE_THREE_TO_TWO: begin
        io_out[3]    = lut3(tbl_a3_fst_q, io_sync_q[2:0]);
        io_out[4]    = lut3(tbl_a3_snd_q, io_sync_q[2:0]);
        lut_drive[4:3] = 2'b11;
      end
      default: begin
      end
    endcase
    // Mode 11 of the high half is reserved and decodes nothing.
    // high half decode
    case (a_high_q)
      `GLC_MODE_GPIO: begin
      end
      `GLC_MODE_TWO_TO_ONE: begin
        io_out[6]    = lut2(tbl_a2_q[7:4], io_sync_q[5:4]);
        lut_drive[6] = 1'b1;
      end
      `GLC_MODE_THREE_TO_ONE: begin
        io_out[7]    = lut3(tbl_a3_high_q, io_sync_q[6:4]);
        lut_drive[7] = 1'b1;
      end
      default: begin
      end
    endcase
    // Bank B 3-to-1 and 3-to-2 tables live elsewhere, so 10 and 11 decode nothing here.
    // low nibble gated
    case (b_low_q)
      `GLC_MODE_TWO_TO_ONE: begin
        io_out[10]    = lut2(tbl_b2_q[3:0], io_sync_q[9:8]);
        lut_drive[10] = 1'b1;
      end
      default: begin
      end
    endcase
    case (b_high_q)
      `GLC_MODE_TWO_TO_ONE: begin
        io_out[14]    = lut2(tbl_b2_q[7:4], io_sync_q[13:12]);
        lut_drive[14] = 1'b1;
      end
      default: begin
      end
    endcase
  end

endmodule // glc_top

// file: glc_map.vh
`ifndef GLC_MAP_VH
`define GLC_MAP_VH

// Register offsets.
`define GLC_ADDR_MODE_B        8'h20
`define GLC_ADDR_MODE_A        8'h21
`define GLC_ADDR_TABLE_B2      8'h22
`define GLC_ADDR_TABLE_A2      8'h23
`define GLC_ADDR_TABLE_A3      8'h25
`define GLC_ADDR_TABLE_A3_FST  8'h26
`define GLC_ADDR_TABLE_A3_SND  8'h27
`define GLC_ADDR_TABLE_A3_HIGH 8'h28

// Reset values.
`define GLC_RST_MODE           2'h0
`define GLC_RST_TABLE          8'h00
`define GLC_RST_NIBBLE         4'h0

// Mode field positions and encodings.
`define GLC_MODE_LOW_LSB       3'h0
`define GLC_MODE_HIGH_LSB      3'h4
`define GLC_MODE_GPIO          2'h0
`define GLC_MODE_TWO_TO_ONE    2'h1
`define GLC_MODE_THREE_TO_ONE  2'h2
`define GLC_MODE_THREE_TO_TWO  2'h3

`endif

// file: glc_properties.sv
`timescale 1ns/1ps
module glc_checker #(parameter WIDTH = 16) (
  // Clock and reset
  input wire             mclk,
  input wire             rst,
  // Register port
  input wire             reg_wr,
  input wire             reg_rd,
  input wire [7:0]       reg_addr,
  input wire [7:0]       reg_wdata,
  input wire [7:0]       reg_rdata_q,
  // I/O lines
  input wire [WIDTH-1:0] io_pin,
  input wire [WIDTH-1:0] gpio_data,
  input wire [WIDTH-1:0] io_out,
  input wire [WIDTH-1:0] lut_drive
);
  reg [7:0]       ma, mb, tb, ta, t3, tf, ts, th;
  reg [WIDTH-1:0] p1, p2;
  always @(posedge mclk) begin
    p1 <= rst ? 0 : io_pin;
    p2 <= rst ? 0 : p1;
    if (rst) {ma, mb, tb, ta, t3, tf, ts, th} <= 0;
    else if (reg_wr) begin
      if (reg_addr == 8'h21) ma <= reg_wdata & 8'h33;
      if (reg_addr == 8'h20) mb <= reg_wdata & 8'h33;
      if (reg_addr == 8'h22) tb <= reg_wdata;
      if (reg_addr == 8'h23) ta <= reg_wdata;
      if (reg_addr == 8'h25) t3 <= reg_wdata;
      if (reg_addr == 8'h26) tf <= reg_wdata;
      if (reg_addr == 8'h27) ts <= reg_wdata;
      if (reg_addr == 8'h28) th <= reg_wdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_A_GPIO: assert property (ma[1:0] == 0 |-> lut_drive[3:0] == 0 &&
    io_out[3:0] == gpio_data[3:0]) else $error("mode 00 not plain GPIO");
  AST_A_TWO: assert property (ma[1:0] == 1 |-> lut_drive[2] &&
    io_out[2] == ta[p2[1:0]]) else $error("line 2 lookup wrong");
  AST_A_THREE: assert property (ma[1:0] == 2 |-> lut_drive[4:0] == 5'h08 &&
    io_out[3] == t3[p2[2:0]]) else $error("3-to-1 lookup wrong");
  AST_A_PAIR: assert property (ma[1:0] == 3 |-> lut_drive[4:3] == 2'h3 &&
    io_out[3] == tf[p2[2:0]] && io_out[4] == ts[p2[2:0]]) else $error("3-to-2 lookup wrong");
  AST_B_HIGH: assert property (mb[5:4] == 1 |-> lut_drive[14] &&
    io_out[14] == tb[{1'b1, p2[13:12]}]) else $error("line 14 lookup wrong");
  AST_B_HIGH_OFF: assert property (mb[5:4] != 1 |-> !lut_drive[14])
    else $error("line 14 driven outside 2-to-1");
  AST_B_LOW: assert property (mb[1:0] == 1 |-> lut_drive[10] &&
    io_out[10] == tb[{1'b0, p2[9:8]}]) else $error("line 10 lookup wrong");
  AST_B_LOW_OFF: assert property (mb[1:0] != 1 |-> !lut_drive[10])
    else $error("line 10 driven outside 2-to-1");
  AST_A_HIGH: assert property (ma[5:4] == 1 |-> lut_drive[6] &&
    io_out[6] == ta[{1'b1, p2[5:4]}]) else $error("line 6 lookup wrong");
  AST_A_HIGH_THREE: assert property (ma[5:4] == 2 |-> lut_drive[7] &&
    io_out[7] == th[p2[6:4]]) else $error("line 7 lookup wrong");
  AST_MODE_RD: assert property (reg_rd && reg_addr == 8'h21 |=>
    reg_rdata_q == $past(ma)) else $error("mode readback wrong");
endmodule // glc_checker
bind glc_top glc_checker #(.WIDTH(WIDTH)) i_chk (.*);

// file: glc_host.sv
`timescale 1ns/1ps
module glc_host (
  input wire       mclk,
  input wire [7:0] reg_rdata_q,
  output reg       reg_wr = 0,
  output reg       reg_rd = 0,
  output reg [7:0] reg_addr = 8'h00,
  output reg [7:0] reg_wdata = 8'h00
);
  task wr(input [7:0] a, input [7:0] d); begin
    @(posedge mclk); #1;
    reg_addr = a;
    reg_wdata = (a == 8'h20 || a == 8'h21) ? d & 8'h33 : d;
    reg_wr = 1;
    @(posedge mclk); #1;
    reg_wr = 0;
    reg_wdata = ~reg_wdata;
  end endtask
  task rd(input [7:0] a, output [7:0] d); begin
    @(posedge mclk); #1;
    reg_addr = a;
    reg_rd = 1;
    @(posedge mclk); #1;
    reg_rd = 0;
    d = reg_rdata_q;
  end endtask
endmodule // glc_host

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg         mclk = 0, rst = 1;
  reg  [15:0] io_pin = 0, gpio_data = 16'h5a3c;
  wire        reg_wr, reg_rd;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata_q;
  wire [15:0] io_out, lut_drive;
  reg  [7:0]  d, t = 8'ha5;
  reg  [7:0]  ta2 = 8'h96, ta3 = 8'h69, tf = 8'hc3, ts = 8'h3c, th = 8'h5a;
  reg  [31:0] la = 32'h1808_0400;
  integer     bad_count = 0, check_count = 0, i;
  initial forever #10 mclk = ~mclk;
  glc_top #(.WIDTH(16)) i_dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .io_pin(io_pin),
    .gpio_data(gpio_data), .io_out(io_out), .lut_drive(lut_drive));
  glc_host i_host (.mclk(mclk), .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  task chk(input [15:0] got, input [15:0] exp); begin
    check_count = check_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  end endtask
  task pins(input [2:0] v); begin
    io_pin = {9'h000, v, 1'b0, v};
    repeat (2) @(posedge mclk);
    #1;
  end endtask
  task close_out; begin
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask
  initial begin
    #100000;
    bad_count = bad_count + 1;
    close_out;
  end
  initial begin
    repeat (8) @(posedge mclk);
    #1 rst = 0;
    i_host.rd(8'h21, d); chk(d, 8'h00);
    i_host.rd(8'h22, d); chk(d, 8'h00);
    i_host.wr(8'h22, t);
    i_host.wr(8'h20, 8'h11);
    for (i = 0; i < 4; i = i + 1) begin
      io_pin = {2'b00, i[1:0], 2'b00, i[1:0], 8'h00};
      repeat (2) @(posedge mclk);
      #1 chk(io_out[14], t[4+i]);
      chk(io_out[10], t[i]);
      chk(lut_drive, 16'h4400);
    end
    i_host.wr(8'h20, 8'h00);
    chk(io_out, gpio_data);
    gpio_data = 16'hc3a5;
    #1 chk(io_out, gpio_data);
    for (i = 0; i < 4; i = i + 1) begin
      i_host.wr(8'h21, i[7:0]);
      chk(lut_drive[4:0], la[8*i+:5]);
    end
    i_host.wr(8'h23, ta2);
    i_host.wr(8'h25, ta3);
    i_host.wr(8'h26, tf);
    i_host.wr(8'h27, ts);
    i_host.wr(8'h28, th);
    i_host.wr(8'h21, 8'h11);
    for (i = 0; i < 4; i = i + 1) begin
      pins(i[2:0]);
      chk(io_out[2], ta2[i]);
      chk(io_out[6], ta2[4+i]);
      chk(lut_drive, 16'h0044);
    end
    i_host.wr(8'h21, 8'h22);
    for (i = 0; i < 8; i = i + 1) begin
      pins(i[2:0]);
      chk(io_out[3], ta3[i]);
      chk(io_out[7], th[i]);
      chk(lut_drive, 16'h0088);
    end
    i_host.wr(8'h21, 8'h03);
    for (i = 0; i < 8; i = i + 1) begin
      pins(i[2:0]);
      chk(io_out[3], tf[i]);
      chk(io_out[4], ts[i]);
      chk(lut_drive, 16'h0018);
    end
    chk(io_out & 16'hffe7, gpio_data & 16'hffe7);
    i_host.rd(8'h23, d);
    chk(d, ta2);
    i_host.rd(8'h25, d);
    chk(d, ta3);
    i_host.rd(8'h26, d);
    chk(d, tf);
    i_host.rd(8'h27, d);
    chk(d, ts);
    i_host.rd(8'h28, d);
    chk(d, th);
    i_host.wr(8'h21, 8'hff);
    i_host.rd(8'h21, d); chk(d, 8'h33);
    i_host.rd(8'h22, d); chk(d, t);
    i_host.rd(8'h24, d); chk(d, 8'h00);
    rst = 1;
    repeat (2) @(posedge mclk);
    #1 rst = 0;
    chk(lut_drive, 16'h0000);
    chk(io_out, gpio_data);
    i_host.rd(8'h21, d);
    chk(d, 8'h00);
    i_host.rd(8'h22, d);
    chk(d, 8'h00);
    close_out;
  end
endmodule // tb_top
